// >>> rtl/rwd_bcd_down.sv
`default_nettype none
// ========================================
// Four-digit BCD down counter, reload has priority
module rwd_bcd_down (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [15:0] loadValue,
    input  wire logic        tick,
    output logic             timeout,
    output logic [15:0]      countQ
);
    import rwd_pkg::*;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [4:0]  borrow;
    genvar g;
    assign borrow[0] = 1'b1;
    generate
        for (g = 0; g < 4; g++) begin : g_dig
            assign cnt_d[4*g+3:4*g] = !borrow[g] ? cnt_q[4*g+3:4*g] :
                (cnt_q[4*g+3:4*g] == 4'h0) ? 4'h9 : cnt_q[4*g+3:4*g] - 4'h1;
            assign borrow[g+1] = borrow[g] && (cnt_q[4*g+3:4*g] == 4'h0);
        end
    endgenerate
    assign timeout = tick && (cnt_q == 16'h0001) && !load;
    assign countQ  = cnt_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
        end else if (load || timeout) begin
            cnt_q <= loadValue;
        end else if (tick && cnt_q != 16'h0000) begin
            cnt_q <= cnt_d;
        end
    end
endmodule : rwd_bcd_down
`default_nettype wire

// >>> rtl/rwd_pkg.sv
`default_nettype none
package rwd_pkg;
    // ========================================
    // Register offsets
    localparam logic [4:0] ADDR_WD_PERIOD_A = 5'h0C;
    localparam logic [4:0] ADDR_WD_PERIOD_B = 5'h0D;
    localparam logic [4:0] ADDR_FLAG_REG    = 5'h0E;
    localparam logic [4:0] ADDR_SECOND_CTRL = 5'h0F;
    // ========================================
    // Flag register fields
    localparam int BIT_ALARM_FLAG = 3;
    localparam int BIT_KICK_FLAG  = 2;
    localparam int BIT_WD_FLAG    = 1;
    localparam int BIT_IRQ_FLAG   = 0;
    // ========================================
    // Second control fields
    localparam int BIT_TRANSFER   = 7;
    localparam int BIT_XTAL_SEL   = 6;
    localparam int BIT_BURST      = 5;
    localparam int BIT_ALARM_PWR  = 4;
    localparam int BIT_ALARM_IRQ  = 3;
    localparam int BIT_KICK_EN    = 2;
    localparam int BIT_WD_EN      = 1;
    localparam int BIT_WD_STEER   = 0;
    localparam logic [7:0] SECOND_CTRL_RESET = 8'h00;
    localparam logic [7:0] WD_PERIOD_RESET   = 8'h00;
    // ========================================
    // Timing
    localparam int  CLK_MHZ          = 250;
    localparam int  ADDR_STABLE_NS   = 15;
    localparam int  ADDR_STABLE_CYC  = (ADDR_STABLE_NS * CLK_MHZ + 999) / 1000;
    localparam int  TICK_HZ          = 100;
    localparam int  TICK_DIV         = CLK_MHZ * 1000000 / TICK_HZ;
    localparam int  RECOVERY_MS      = 150;
    localparam int  RECOVERY_CYC     = RECOVERY_MS * CLK_MHZ * 1000;
endpackage : rwd_pkg
`default_nettype wire

// >>> rtl/rwd_read_clear.sv
`default_nettype none
// ========================================
// Arms after address held stable, fires when the read ends
module rwd_read_clear (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       readActive,
    input  wire logic [4:0] addr,
    output logic            clearPulse
);
    import rwd_pkg::*;
    logic [4:0] addr_q;
    logic [3:0] stable_q;
    logic       armed_q;
    logic       hit;
    assign hit = readActive && addr == ADDR_FLAG_REG && addr == addr_q;
    // Clear lands on address change or strobe release, so data read is intact
    assign clearPulse = armed_q && !(hit);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_q   <= 5'h00;
            stable_q <= 4'h0;
            armed_q  <= 1'b0;
        end else begin
            addr_q <= addr;
            if (!hit) begin
                stable_q <= 4'h0;
                armed_q  <= 1'b0;
            end else if (stable_q < 4'(ADDR_STABLE_CYC)) begin
                stable_q <= stable_q + 4'h1;
            end else begin
                armed_q <= 1'b1;
            end
        end
    end
endmodule : rwd_read_clear
`default_nettype wire

// >>> rtl/rwd_watchdog_ctrl.sv
`default_nettype none
// Operation
// - Reading flag register clears event flags
// - Clear after stable address, at read end
// - Interrupt output released when request clears
// - Writing zero clears alarm, watchdog flags
// - Transfer enable gates once-per-second updates
// - Transfer enable changed only by host
// - Crystal select picks load capacitance
// - Burst enable auto-increments RAM address
// - Alarm flag with power enable drives power
// - Alarm interrupt enable gates request flag
// - Kickstart without supply drives power output
// - Kickstart with supply drives both outputs
// - Watchdog enable routes event to output
// - Steering picks interrupt or reset pulse
// - Oscillator runs only when enable low
// - Period from two BCD registers, 10ms
// - Counter reloads period on every timeout
// - Nonzero period timeout sets watchdog flag
// - Period register write restarts counter
// - Single-shot resets then clears watchdog enable
// - Zero period disables watchdog entirely
// - Power-on clears enable and steering
// - Request flag is OR of enabled flags
// - No host write in period sets flag
module rwd_watchdog_ctrl #(
    parameter int TICK_CYCLES     = rwd_pkg::TICK_DIV,
    parameter int RECOVERY_CYCLES = rwd_pkg::RECOVERY_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       chipSelectN,
    input  wire logic       readEnableN,
    input  wire logic       writeEnableN,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] writeData,
    output logic [7:0]      readData,
    input  wire logic       oscillatorEnableN,
    input  wire logic       mainSupply,
    input  wire logic       kickstartInN,
    input  wire logic       alarmMatch,
    input  wire logic       ramAccess,
    output logic            interruptOutN,
    output logic            resetOutN,
    output logic            powerControlOutN,
    output logic            updateTransferEnable,
    output logic            crystalLoadSelect,
    output logic            ramAddrIncrement,
    output logic            oscillatorRun
);
    import rwd_pkg::*;

    // ========================================
    // Host access decode
    logic wrStrobe;
    logic wrPrev_q;
    logic wrEdge;
    logic readActive;
    logic wrFlag;
    logic wrCtrl;
    logic wrPerA;
    logic wrPerB;
    assign readActive = !chipSelectN && !readEnableN;
    assign wrStrobe   = !chipSelectN && !writeEnableN;
    // One action per write strobe, held strobes are not repeated
    assign wrEdge = wrStrobe && !wrPrev_q;
    // Unmapped offsets fall to the default and are ignored on write
    always_comb begin
        wrFlag = 1'b0;
        wrCtrl = 1'b0;
        wrPerA = 1'b0;
        wrPerB = 1'b0;
        if (wrEdge) begin
            case (addr)
                ADDR_WD_PERIOD_A: wrPerA = 1'b1;
                ADDR_WD_PERIOD_B: wrPerB = 1'b1;
                ADDR_FLAG_REG:    wrFlag = 1'b1;
                ADDR_SECOND_CTRL: wrCtrl = 1'b1;
                default:          wrFlag = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPrev_q <= 1'b0;
        end else begin
            wrPrev_q <= wrStrobe;
        end
    end

    // ========================================
    // Second control register
    logic [7:0] ctrl_q;
    logic       singleShotDone;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= SECOND_CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= writeData;
            end
            if (singleShotDone) begin
                ctrl_q[BIT_WD_EN] <= 1'b0;
            end
        end
    end
    assign updateTransferEnable = ctrl_q[BIT_TRANSFER];
    assign crystalLoadSelect    = ctrl_q[BIT_XTAL_SEL];
    assign ramAddrIncrement     = ctrl_q[BIT_BURST] && ramAccess;
    assign oscillatorRun        = !oscillatorEnableN;

    // ========================================
    // Watchdog period registers
    // Contents are undefined to software until written; zero here disables
    logic [7:0] perA_q;
    logic [7:0] perB_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            perA_q <= WD_PERIOD_RESET;
        end else if (wrPerA) begin
            perA_q <= writeData;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            perB_q <= WD_PERIOD_RESET;
        end else if (wrPerB) begin
            perB_q <= writeData;
        end
    end

    // ========================================
    // Period as it stands after this edge, so a reload never sees stale data
    logic [7:0] perANext;
    logic [7:0] perBNext;
    always_comb begin
        perANext = perA_q;
        perBNext = perB_q;
        if (wrPerA) begin
            perANext = writeData;
        end
        if (wrPerB) begin
            perBNext = writeData;
        end
    end

    // ========================================
    // 100 Hz tick from the running oscillator
    // Divider restarts when the oscillator stops, so the first tick is full
    logic [31:0] tickCnt_q;
    logic        tick;
    assign tick = oscillatorRun && tickCnt_q == 32'(TICK_CYCLES - 1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tickCnt_q <= 32'h00000000;
        end else if (!oscillatorRun || tick) begin
            tickCnt_q <= 32'h00000000;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h00000001;
        end
    end

    // ========================================
    // Watchdog countdown
    logic        periodNonzero;
    logic        wdLoad;
    logic        wdTimeout;
    logic        wdFire;
    logic [15:0] wdPeriod;
    logic [15:0] wdReload;
    assign wdPeriod      = {perB_q, perA_q};
    // Reload takes the byte written at the same edge
    assign wdReload      = {perBNext, perANext};
    assign periodNonzero = wdPeriod != 16'h0000;
    // Any host write kicks the watchdog, period writes included
    assign wdLoad = wrEdge;
    assign wdFire = wdTimeout && periodNonzero;

    rwd_bcd_down u_count (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .load      (wdLoad),
        .loadValue (wdReload),
        .tick      (tick),
        .timeout   (wdTimeout),
        .countQ    ()
    );

    // ========================================
    // Read-clear detection
    logic readClear;
    rwd_read_clear u_rdclr (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .readActive (readActive),
        .addr       (addr),
        .clearPulse (readClear)
    );

    // ========================================
    // Event flags, a set wins over a same-cycle clear
    logic alarmFlag_q;
    logic kickFlag_q;
    logic wdFlag_q;
    logic kickPrev_q;
    logic kickEvent;
    assign kickEvent = kickPrev_q && !kickstartInN;

    logic alarmClear;
    logic wdClear;
    logic kickSet;
    logic kickClear;
    // A flag write clears only where a zero is written to that bit
    assign alarmClear = readClear || (wrFlag && !writeData[BIT_ALARM_FLAG]);
    assign wdClear    = readClear || (wrFlag && !writeData[BIT_WD_FLAG]);
    assign kickSet    = kickEvent || (wrFlag && writeData[BIT_KICK_FLAG]);
    assign kickClear  = readClear || wrFlag;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kickPrev_q <= 1'b1;
        end else begin
            kickPrev_q <= kickstartInN;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarmFlag_q <= 1'b0;
        end else if (alarmMatch) begin
            alarmFlag_q <= 1'b1;
        end else if (alarmClear) begin
            alarmFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kickFlag_q <= 1'b0;
        end else if (kickSet) begin
            kickFlag_q <= 1'b1;
        end else if (kickClear) begin
            kickFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdFlag_q <= 1'b0;
        end else if (wdFire) begin
            wdFlag_q <= 1'b1;
        end else if (wdClear) begin
            wdFlag_q <= 1'b0;
        end
    end

    // ========================================
    // Interrupt request, steering and power control
    logic irqFlag;
    logic wdIrqTerm;
    logic kickIrqTerm;
    assign kickIrqTerm = kickFlag_q && ctrl_q[BIT_KICK_EN] && mainSupply;
    // Steering set sends the watchdog to the reset pin instead
    assign wdIrqTerm = wdFlag_q && ctrl_q[BIT_WD_EN] && !ctrl_q[BIT_WD_STEER];
    logic alarmIrqTerm;
    assign alarmIrqTerm = alarmFlag_q && ctrl_q[BIT_ALARM_IRQ];
    assign irqFlag = alarmIrqTerm || kickIrqTerm || wdIrqTerm;

    logic irqOutN_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqOutN_q <= 1'b1;
        end else begin
            irqOutN_q <= !irqFlag;
        end
    end
    assign interruptOutN = irqOutN_q;

    // Power pin has no supply gate: it must wake a system that is still off
    logic alarmPwrTerm;
    logic kickPwrTerm;
    logic pwrRequest;
    assign alarmPwrTerm = alarmFlag_q && ctrl_q[BIT_ALARM_PWR];
    assign kickPwrTerm  = kickFlag_q && ctrl_q[BIT_KICK_EN];
    assign pwrRequest   = alarmPwrTerm || kickPwrTerm;

    logic pwrN_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwrN_q <= 1'b1;
        end else begin
            pwrN_q <= !pwrRequest;
        end
    end
    assign powerControlOutN = pwrN_q;

    // ========================================
    // Single-shot reset pulse
    // Counter is wide enough for the full recovery time at this clock
    logic [31:0] recCnt_q;
    logic        rstActive_q;
    logic        wdRstTerm;
    assign wdRstTerm = wdFire && ctrl_q[BIT_WD_EN] && ctrl_q[BIT_WD_STEER];
    assign singleShotDone = rstActive_q && recCnt_q == 32'(RECOVERY_CYCLES - 1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rstActive_q <= 1'b0;
            recCnt_q    <= 32'h00000000;
        end else if (rstActive_q) begin
            recCnt_q <= recCnt_q + 32'h00000001;
            if (singleShotDone) begin
                rstActive_q <= 1'b0;
            end
        end else if (wdRstTerm) begin
            rstActive_q <= 1'b1;
            recCnt_q    <= 32'h00000000;
        end
    end
    assign resetOutN = !rstActive_q;

    // ========================================
    // Read data, registered; host must hold software order on TE
    // before touching the period registers
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        case (addr)
            ADDR_WD_PERIOD_A: rdMux = perA_q;
            ADDR_WD_PERIOD_B: rdMux = perB_q;
            ADDR_FLAG_REG:    rdMux = {4'h0, alarmFlag_q, kickFlag_q, wdFlag_q, irqFlag};
            ADDR_SECOND_CTRL: rdMux = ctrl_q;
            default:          rdMux = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (readActive) begin
            readData <= rdMux;
        end
    end
endmodule : rwd_watchdog_ctrl
`default_nettype wire

// >>> test/rwd_host_model.sv
`default_nettype none
// ======
// Host processor on the byte-wide register port
module rwd_host_model (
    input  wire logic       clk_sys,
    output logic            chipSelectN,
    output logic            readEnableN,
    output logic            writeEnableN,
    output logic [4:0]      addr,
    output logic [7:0]      writeData,
    input  wire logic [7:0] readData
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        chipSelectN  = 1'b1;
        readEnableN  = 1'b1;
        writeEnableN = 1'b1;
        addr         = 5'h00;
        writeData    = 8'h00;
    end
    // Deselected: old address and data must not look valid
    task automatic release_bus();
        chipSelectN  = 1'b1;
        readEnableN  = 1'b1;
        writeEnableN = 1'b1;
        addr         = ~addr;
        writeData    = ~writeData;
    endtask : release_bus
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        chipSelectN  = 1'b0;
        writeEnableN = 1'b0;
        addr         = a;
        writeData    = d;
        @(posedge clk_sys);
        #1;
        release_bus();
    endtask : wr
    // A short hold leaves the flags alone, a long one meets the stable time
    task automatic rd(input logic [4:0] a, input int hold, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        chipSelectN = 1'b0;
        readEnableN = 1'b0;
        addr        = a;
        repeat (hold) @(posedge clk_sys);
        #1;
        d = readData;
        release_bus();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : rd
endmodule : rwd_host_model
`default_nettype wire

// >>> test/rwd_watchdog_ctrl_properties.sv
`default_nettype none
// ======
// Port checks of the watchdog control block
module rwd_watchdog_ctrl_checker #(
    parameter int RECOVERY_CYCLES = 8
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       chipSelectN,
    input wire logic       readEnableN,
    input wire logic       writeEnableN,
    input wire logic [4:0] addr,
    input wire logic [7:0] readData,
    input wire logic       oscillatorEnableN,
    input wire logic       mainSupply,
    input wire logic       ramAccess,
    input wire logic       interruptOutN,
    input wire logic       resetOutN,
    input wire logic       updateTransferEnable,
    input wire logic       crystalLoadSelect,
    input wire logic       ramAddrIncrement,
    input wire logic       oscillatorRun
);
    import rwd_pkg::*;
    int lowCnt_q;
    // Pulse width by counter, the recovery count is too long to repeat
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lowCnt_q <= 0;
        end else begin
            lowCnt_q <= resetOutN ? 0 : lowCnt_q + 1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    AST_OSC_RUN: assert property (oscillatorRun == !oscillatorEnableN)
        else $error("oscillator run does not follow its enable");
    AST_BURST_STEP: assert property (ramAddrIncrement |-> ramAccess)
        else $error("address step without a ram access");
    AST_RST_WIDTH: assert property ($rose(resetOutN) |-> lowCnt_q == RECOVERY_CYCLES)
        else $error("reset pulse has the wrong width");
    AST_RST_GAP: assert property ($rose(resetOutN) |-> resetOutN [*3])
        else $error("reset pulse retriggered at once");
    AST_TE_HOST: assert property (!$stable(updateTransferEnable)
        |-> $past(!chipSelectN && !writeEnableN))
        else $error("transfer enable changed without a write");
    AST_XTAL_HOST: assert property (!$stable(crystalLoadSelect)
        |-> $past(!chipSelectN && !writeEnableN))
        else $error("crystal select changed without a write");
    AST_CTRL_READ: assert property (!chipSelectN && !readEnableN && addr == ADDR_SECOND_CTRL
        |=> readData[7:6] == $past({updateTransferEnable, crystalLoadSelect}))
        else $error("control read does not match control outputs");
    AST_IRQ_STANDS: assert property ((!interruptOutN && chipSelectN && mainSupply) [*4]
        |=> !interruptOutN)
        else $error("interrupt released without host access");
endmodule : rwd_watchdog_ctrl_checker
bind rwd_watchdog_ctrl rwd_watchdog_ctrl_checker #(
    .RECOVERY_CYCLES(RECOVERY_CYCLES)
) chk (
    .clk_sys(clk_sys), .rst(rst), .chipSelectN(chipSelectN),
    .readEnableN(readEnableN), .writeEnableN(writeEnableN), .addr(addr),
    .readData(readData), .oscillatorEnableN(oscillatorEnableN),
    .mainSupply(mainSupply), .ramAccess(ramAccess), .interruptOutN(interruptOutN),
    .resetOutN(resetOutN), .updateTransferEnable(updateTransferEnable),
    .crystalLoadSelect(crystalLoadSelect), .ramAddrIncrement(ramAddrIncrement),
    .oscillatorRun(oscillatorRun)
);
`default_nettype wire

// >>> test/rwd_watchdog_ctrl_tb.sv
`default_nettype none
module rwd_watchdog_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rwd_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       oscillatorEnableN = 1'b0;
    logic       mainSupply = 1'b1;
    logic       kickstartInN = 1'b1;
    logic       alarmMatch = 1'b0;
    logic       ramAccess = 1'b0;
    logic       chipSelectN, readEnableN, writeEnableN;
    logic [4:0] addr;
    logic [7:0] writeData, readData, rdv;
    logic       interruptOutN, resetOutN, powerControlOutN;
    logic       updateTransferEnable, crystalLoadSelect, ramAddrIncrement, oscillatorRun;
    int         errors = 0;
    int         cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    rwd_host_model host (
        .clk_sys(clk_sys), .chipSelectN(chipSelectN), .readEnableN(readEnableN),
        .writeEnableN(writeEnableN), .addr(addr), .writeData(writeData),
        .readData(readData)
    );
    rwd_watchdog_ctrl #(.TICK_CYCLES(4), .RECOVERY_CYCLES(8)) dut (
        .clk_sys(clk_sys), .rst(rst), .chipSelectN(chipSelectN),
        .readEnableN(readEnableN), .writeEnableN(writeEnableN), .addr(addr),
        .writeData(writeData), .readData(readData),
        .oscillatorEnableN(oscillatorEnableN), .mainSupply(mainSupply),
        .kickstartInN(kickstartInN), .alarmMatch(alarmMatch), .ramAccess(ramAccess),
        .interruptOutN(interruptOutN), .resetOutN(resetOutN),
        .powerControlOutN(powerControlOutN), .updateTransferEnable(updateTransferEnable),
        .crystalLoadSelect(crystalLoadSelect), .ramAddrIncrement(ramAddrIncrement),
        .oscillatorRun(oscillatorRun)
    );
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic rchk(input logic [4:0] a, input int hold, input logic [7:0] exp);
        host.rd(a, hold, rdv);
        check(rdv, exp);
    endtask : rchk
    task automatic wait_low(input bit useRst, input int limit);
        int n;
        n = 0;
        while ((useRst ? resetOutN : interruptOutN) !== 1'b0 && n <= limit) begin
            step(1);
            n++;
        end
        check({7'h00, n <= limit}, 8'h01);
    endtask : wait_low
    task automatic pulse(input bit kick);
        if (kick) kickstartInN = 1'b0;
        else alarmMatch = 1'b1;
        step(2);
        kickstartInN = 1'b1;
        alarmMatch = 1'b0;
        step(3);
    endtask : pulse
    initial begin
        #40000;
        errors++;
        complete_run();
    end
    initial begin
        step(16);
        rst = 1'b0;
        // ======
        // Reset state, control outputs
        rchk(ADDR_SECOND_CTRL, 8, SECOND_CTRL_RESET);
        rchk(ADDR_FLAG_REG, 8, 8'h00);
        rchk(5'h1A, 8, 8'h00);
        host.wr(ADDR_SECOND_CTRL, 8'hE2);
        rchk(ADDR_SECOND_CTRL, 8, 8'hE2);
        oscillatorEnableN = 1'b1;
        ramAccess = 1'b1;
        step(1);
        check({4'h0, updateTransferEnable, crystalLoadSelect, ramAddrIncrement,
               oscillatorRun}, 8'h0E);
        ramAccess = 1'b0;
        oscillatorEnableN = 1'b0;
        check({6'h00, interruptOutN, resetOutN}, 8'h03);
        // ======
        // Kickstart, disabled then with supply absent
        host.wr(ADDR_SECOND_CTRL, 8'h00);
        pulse(1'b1);
        check({6'h00, interruptOutN, powerControlOutN}, 8'h03);
        rchk(ADDR_FLAG_REG, 8, 8'h04);
        host.wr(ADDR_SECOND_CTRL, 8'h04);
        mainSupply = 1'b0;
        pulse(1'b1);
        check({6'h00, interruptOutN, powerControlOutN}, 8'h02);
        mainSupply = 1'b1;
        step(3);
        check({6'h00, interruptOutN, powerControlOutN}, 8'h00);
        rchk(ADDR_FLAG_REG, 8, 8'h05);
        check({7'h00, interruptOutN}, 8'h01);
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        check({6'h00, interruptOutN, powerControlOutN}, 8'h03);
        // ======
        // Alarm to power only, then to interrupt
        host.wr(ADDR_SECOND_CTRL, 8'h10);
        pulse(1'b0);
        check({6'h00, interruptOutN, powerControlOutN}, 8'h02);
        rchk(ADDR_FLAG_REG, 2, 8'h08);
        host.wr(ADDR_FLAG_REG, 8'h00);
        rchk(ADDR_FLAG_REG, 2, 8'h00);
        host.wr(ADDR_SECOND_CTRL, 8'h08);
        pulse(1'b0);
        check({7'h00, interruptOutN}, 8'h00);
        rchk(ADDR_FLAG_REG, 2, 8'h09);
        rchk(ADDR_FLAG_REG, 8, 8'h09);
        rchk(ADDR_FLAG_REG, 2, 8'h00);
        check({7'h00, interruptOutN}, 8'h01);
        // ======
        // Watchdog, transfers stopped while the period is written
        host.wr(ADDR_SECOND_CTRL, 8'h00);
        host.wr(ADDR_WD_PERIOD_A, 8'h02);
        host.wr(ADDR_WD_PERIOD_B, 8'h00);
        step(20);
        rchk(ADDR_FLAG_REG, 8, 8'h02);
        host.wr(ADDR_SECOND_CTRL, 8'h02);
        wait_low(1'b0, 12);
        rchk(ADDR_FLAG_REG, 8, 8'h03);
        wait_low(1'b0, 20);
        host.wr(ADDR_FLAG_REG, 8'h00);
        repeat (10) host.wr(ADDR_WD_PERIOD_A, 8'h02);
        check({7'h00, interruptOutN}, 8'h01);
        host.wr(ADDR_SECOND_CTRL, 8'h03);
        wait_low(1'b1, 12);
        step(12);
        check({7'h00, interruptOutN}, 8'h01);
        rchk(ADDR_SECOND_CTRL, 8, 8'h01);
        host.wr(ADDR_WD_PERIOD_A, 8'h00);
        host.wr(ADDR_FLAG_REG, 8'h00);
        step(30);
        rchk(ADDR_FLAG_REG, 8, 8'h00);
        complete_run();
    end
endmodule : rwd_watchdog_ctrl_tb
`default_nettype wire
